// File: inc/crt_defines.svh
`ifndef CRT_DEFINES_SVH
`define CRT_DEFINES_SVH

// ----------------------------------------------------------------
// register addresses on the special-function bus
// ----------------------------------------------------------------
`define CRT_ADDR_CTRL     8'hC8
`define CRT_ADDR_CNT_LO   8'hC9
`define CRT_ADDR_CNT_HI   8'hCA
`define CRT_ADDR_CAP_LO   8'hCB
`define CRT_ADDR_CAP_HI   8'hCC

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define CRT_BIT_OVF_FLAG  7
`define CRT_BIT_EXT_FLAG  6
`define CRT_BIT_RX_SEL    5
`define CRT_BIT_TX_SEL    4
`define CRT_BIT_EXT_EN    3
`define CRT_BIT_RUN       2
`define CRT_BIT_FUNC_SEL  1
`define CRT_BIT_CAP_SEL   0
`define CRT_CTRL_RESET    8'h00
`define CRT_CNT_RESET     16'h0000
`define CRT_CAP_RESET     16'h0000
`define CRT_CNT_MAX       16'hFFFF
`define CRT_RDATA_IDLE    8'h00

// ----------------------------------------------------------------
// oscillator divisions of the count tick
// ----------------------------------------------------------------
`define CRT_TIMER_DIV     12
`define CRT_BAUD_DIV      2

`endif

// File: inc/crt_pkg.sv
package crt_pkg;

    // ----------------------------------------------------------------
    // operating modes of the counter
    // ----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        CRT_MODE_RELOAD  = 2'b00,
        CRT_MODE_CAPTURE = 2'b01,
        CRT_MODE_BAUD    = 2'b10
    } crt_mode_t;

endpackage : crt_pkg

// File: design/crt_prescale.sv
`timescale 1ns/1ps
`include "crt_defines.svh"

module crt_prescale
#(
    parameter int TIMER_DIV = `CRT_TIMER_DIV,
    parameter int BAUD_DIV  = `CRT_BAUD_DIV
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // control
    input  wire logic run,
    input  wire logic baud_sel,
    // tick out
    output logic      tick
);

    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic       tick_next;
    logic [7:0] limit;

    always_comb
    begin
        limit     = baud_sel ? 8'(BAUD_DIV - 1) : 8'(TIMER_DIV - 1);
        div_next  = div_reg;
        tick_next = 1'b0;
        // stopped prescaler restarts cleanly from zero
        if (!run)
        begin
            div_next = 8'h00;
        end
        else if (div_reg >= limit)
        begin
            div_next  = 8'h00;
            tick_next = 1'b1;
        end
        else
        begin
            div_next = div_reg + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            div_reg <= 8'h00;
            tick    <= 1'b0;
        end
        else if (ce)
        begin
            div_reg <= div_next;
            tick    <= tick_next;
        end
    end

endmodule : crt_prescale

// File: design/crt_timer.sv
`timescale 1ns/1ps
`include "crt_defines.svh"


module crt_timer
#(
    parameter int TIMER_DIV = `CRT_TIMER_DIV,
    parameter int BAUD_DIV  = `CRT_BAUD_DIV
)
(
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       ce,
    // special-function bus
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // pins and neighbour timer
    input  wire logic       external_count_pin,
    input  wire logic       trigger_pin,
    input  wire logic       other_timer_ovf,
    // interrupt and uart clocks
    output logic            irq,
    output logic            overflow_pulse,
    output logic            uart_rx_clk,
    output logic            uart_tx_clk
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic cnt_s1_reg;
    logic cnt_s2_reg;
    logic cnt_s3_reg;
    logic trg_s1_reg;
    logic trg_s2_reg;
    logic trg_s3_reg;
    logic cnt_s1_next;
    logic cnt_s2_next;
    logic cnt_s3_next;
    logic trg_s1_next;
    logic trg_s2_next;
    logic trg_s3_next;

    // first stage feeds only the second stage
    always_comb
    begin
        cnt_s1_next = external_count_pin;
        cnt_s2_next = cnt_s1_reg;
        cnt_s3_next = cnt_s2_reg;
        trg_s1_next = trigger_pin;
        trg_s2_next = trg_s1_reg;
        trg_s3_next = trg_s2_reg;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_s1_reg <= 1'b0;
            cnt_s2_reg <= 1'b0;
            cnt_s3_reg <= 1'b0;
            trg_s1_reg <= 1'b0;
            trg_s2_reg <= 1'b0;
            trg_s3_reg <= 1'b0;
        end
        else if (ce)
        begin
            cnt_s1_reg <= cnt_s1_next;
            cnt_s2_reg <= cnt_s2_next;
            cnt_s3_reg <= cnt_s3_next;
            trg_s1_reg <= trg_s1_next;
            trg_s2_reg <= trg_s2_next;
            trg_s3_reg <= trg_s3_next;
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic fell(input logic prev, input logic cur);
        fell = prev & ~cur;
    endfunction : fell

    function automatic logic hit(input logic       wr,
                                 input logic [7:0] addr,
                                 input logic [7:0] want);
        hit = wr & (addr == want);
    endfunction : hit

    // ----------------------------------------------------------------
    // timer state
    // ----------------------------------------------------------------
    logic [7:0]        ctrl_reg;
    logic [7:0]        ctrl_next;
    logic [15:0]       count_reg;
    logic [15:0]       count_next;
    logic [15:0]       cap_reg;
    logic [15:0]       cap_next;
    crt_pkg::crt_mode_t mode;
    logic              baud_use;
    logic              run;
    logic              ext_en;
    logic              tick;
    logic              inc;
    logic              ovf;
    logic              trg_fall;

    always_comb
    begin
        run      = ctrl_reg[`CRT_BIT_RUN];
        ext_en   = ctrl_reg[`CRT_BIT_EXT_EN];
        baud_use = ctrl_reg[`CRT_BIT_RX_SEL] | ctrl_reg[`CRT_BIT_TX_SEL];
    end

    // timer tick: oscillator/12, or oscillator/2 as uart clock
    crt_prescale
    #(
        .TIMER_DIV (TIMER_DIV),
        .BAUD_DIV  (BAUD_DIV)
    )
    u_prescale
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .run      (run),
        .baud_sel (baud_use),
        .tick     (tick)
    );

    always_comb
    begin
        // capture select only matters without uart use
        if (baud_use)
        begin
            mode = crt_pkg::CRT_MODE_BAUD;
        end
        else if (ctrl_reg[`CRT_BIT_CAP_SEL])
        begin
            mode = crt_pkg::CRT_MODE_CAPTURE;
        end
        else
        begin
            mode = crt_pkg::CRT_MODE_RELOAD;
        end
    end

    always_comb
    begin
        // pin count needs high then low samples: at most oscillator/2
        if (ctrl_reg[`CRT_BIT_FUNC_SEL])
        begin
            inc = run & fell(cnt_s3_reg, cnt_s2_reg);
        end
        else
        begin
            inc = run & tick;
        end
        ovf      = inc & (count_reg == `CRT_CNT_MAX);
        trg_fall = ext_en & fell(trg_s3_reg, trg_s2_reg);
    end

    always_comb
    begin
        count_next = count_reg;
        cap_next   = cap_reg;
        ctrl_next  = ctrl_reg;

        // counting never goes down, and stops with the run bit
        if (inc)
        begin
            count_next = count_reg + 16'h0001;
        end
        if (ovf && mode != crt_pkg::CRT_MODE_CAPTURE)
        begin
            count_next = cap_reg;
        end

        case (mode)
            crt_pkg::CRT_MODE_CAPTURE:
            begin
                if (trg_fall)
                begin
                    cap_next = count_reg;
                end
            end
            crt_pkg::CRT_MODE_RELOAD:
            begin
                // reload while stopped would break the frozen count
                if (trg_fall && run)
                begin
                    count_next = cap_reg;
                end
            end
            crt_pkg::CRT_MODE_BAUD:
            begin
                // pin acts as a spare interrupt only
                count_next = count_next;
            end
            default:
            begin
                count_next = count_reg;
            end
        endcase

        // firmware writes land before hardware flag sets
        if (hit(sfr_wr, sfr_addr, `CRT_ADDR_CTRL))
        begin
            ctrl_next = sfr_wdata;
        end
        if (hit(sfr_wr, sfr_addr, `CRT_ADDR_CNT_LO))
        begin
            count_next[7:0] = sfr_wdata;
        end
        if (hit(sfr_wr, sfr_addr, `CRT_ADDR_CNT_HI))
        begin
            count_next[15:8] = sfr_wdata;
        end
        if (hit(sfr_wr, sfr_addr, `CRT_ADDR_CAP_LO))
        begin
            cap_next[7:0] = sfr_wdata;
        end
        if (hit(sfr_wr, sfr_addr, `CRT_ADDR_CAP_HI))
        begin
            cap_next[15:8] = sfr_wdata;
        end

        // set wins over a same-cycle firmware clear
        if (ovf && !baud_use)
        begin
            ctrl_next[`CRT_BIT_OVF_FLAG] = 1'b1;
        end
        if (trg_fall)
        begin
            ctrl_next[`CRT_BIT_EXT_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_reg  <= `CRT_CTRL_RESET;
            count_reg <= `CRT_CNT_RESET;
            cap_reg   <= `CRT_CAP_RESET;
        end
        else if (ce)
        begin
            ctrl_reg  <= ctrl_next;
            count_reg <= count_next;
            cap_reg   <= cap_next;
        end
    end

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    logic [7:0] rdata_next;
    logic       irq_next;
    logic       ovf_pulse_next;
    logic       rx_clk_next;
    logic       tx_clk_next;

    always_comb
    begin
        rdata_next = sfr_rdata;
        if (sfr_rd)
        begin
            case (sfr_addr)
                `CRT_ADDR_CTRL:   rdata_next = ctrl_reg;
                `CRT_ADDR_CNT_LO: rdata_next = count_reg[7:0];
                `CRT_ADDR_CNT_HI: rdata_next = count_reg[15:8];
                `CRT_ADDR_CAP_LO: rdata_next = cap_reg[7:0];
                `CRT_ADDR_CAP_HI: rdata_next = cap_reg[15:8];
                default:          rdata_next = `CRT_RDATA_IDLE;
            endcase
        end
        irq_next = ctrl_next[`CRT_BIT_OVF_FLAG]
                 | ctrl_next[`CRT_BIT_EXT_FLAG];
        ovf_pulse_next = ovf;
        // neighbour overflow passes through unless this unit is chosen
        if (ctrl_reg[`CRT_BIT_RX_SEL])
        begin
            rx_clk_next = ovf;
        end
        else
        begin
            rx_clk_next = other_timer_ovf;
        end
        if (ctrl_reg[`CRT_BIT_TX_SEL])
        begin
            tx_clk_next = ovf;
        end
        else
        begin
            tx_clk_next = other_timer_ovf;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sfr_rdata      <= `CRT_RDATA_IDLE;
            irq            <= 1'b0;
            overflow_pulse <= 1'b0;
            uart_rx_clk    <= 1'b0;
            uart_tx_clk    <= 1'b0;
        end
        else if (ce)
        begin
            sfr_rdata      <= rdata_next;
            irq            <= irq_next;
            overflow_pulse <= ovf_pulse_next;
            uart_rx_clk    <= rx_clk_next;
            uart_tx_clk    <= tx_clk_next;
        end
    end

endmodule : crt_timer

// File: tb/crt_props.sv
`timescale 1ns/1ps
module crt_props
#(
    parameter int TIMER_DIV = 12,
    parameter int BAUD_DIV  = 2
)
(
    // clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       ce,
    // register bus
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // pins and outputs
    input wire logic       trigger_pin,
    input wire logic       other_timer_ovf,
    input wire logic       irq,
    input wire logic       overflow_pulse,
    input wire logic       uart_rx_clk,
    input wire logic       uart_tx_clk
);
    // ----------------------------------------------------------------
    // shadow of firmware-owned control bits; flags are not mirrored
    // ----------------------------------------------------------------
    logic       wr_ctrl;
    logic [5:0] sh_reg;
    logic [1:0] wh_reg;
    logic [1:0] off_reg;
    logic [7:0] th_reg;
    assign wr_ctrl = ce && sfr_wr && sfr_addr == 8'hC8;
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            sh_reg  <= 6'h00;
            off_reg <= 2'h0;
        end
        else
        begin
            if (wr_ctrl)
                sh_reg <= sfr_wdata[5:0];
            if (sh_reg[2])
                off_reg <= 2'h0;
            else if (off_reg != 2'h3)
                off_reg <= off_reg + 2'h1;
        end
        wh_reg <= {wh_reg[0], wr_ctrl};
        th_reg <= {th_reg[6:0], trigger_pin};
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (sys_rst);
    // overflow with no firmware write that could mask the flag
    sequence s_quiet_ovf;
        overflow_pulse && wh_reg == 2'b00;
    endsequence
    ovf_flag_a: assert property (s_quiet_ovf ##0
        ($past(sh_reg[5:4], 2) == 2'b00) |-> irq)
        else $error("overflow did not raise irq");
    baud_noflag_a: assert property (s_quiet_ovf ##0
        ($past(sh_reg[5:4], 2) != 2'b00 && !$past(irq, 2) && &th_reg)
        |-> !irq) else $error("uart overflow raised irq");
    irq_hold_a: assert property (irq && !wr_ctrl |=> irq)
        else $error("irq dropped without firmware clear");
    rx_select_a: assert property (!sh_reg[5] && !$past(sh_reg[5])
        |-> uart_rx_clk == $past(other_timer_ovf))
        else $error("rx clock not from other timer");
    tx_select_a: assert property (!sh_reg[4] && !$past(sh_reg[4])
        |-> uart_tx_clk == $past(other_timer_ovf))
        else $error("tx clock not from other timer");
    ctrl_read_a: assert property (sfr_rd && sfr_addr == 8'hC8
        |=> sfr_rdata[5:0] == $past(sh_reg))
        else $error("control readback wrong");
    run_freeze_a: assert property (off_reg == 2'h3 |-> !overflow_pulse)
        else $error("overflow while stopped");
    pulse_single_a: assert property (overflow_pulse |=> !overflow_pulse)
        else $error("overflow pulse longer than one cycle");
endmodule : crt_props

bind crt_timer crt_props #(.TIMER_DIV(TIMER_DIV), .BAUD_DIV(BAUD_DIV)) u_props
(
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .trigger_pin(trigger_pin),
    .other_timer_ovf(other_timer_ovf), .irq(irq),
    .overflow_pulse(overflow_pulse), .uart_rx_clk(uart_rx_clk),
    .uart_tx_clk(uart_tx_clk)
);

// File: tb/crt_pins.sv
`timescale 1ns/1ps
module crt_pins
(
    // clock
    input  wire logic clk,
    // pins toward the timer
    output logic      trg_pin,
    output logic      cnt_pin,
    output logic      ovf_pulse
);
    // ----------------------------------------------------------------
    // trigger and count pins idle high; each level held at least 3 cycles so the sampler sees it
    // ----------------------------------------------------------------
    initial
    begin
        trg_pin   = 1'b1;
        cnt_pin   = 1'b1;
        ovf_pulse = 1'b0;
    end
    // the neighbour overflow rides along to exercise uart clock muxing
    task automatic fall_trg();
        @(posedge clk);
        #1;
        trg_pin   = 1'b0;
        ovf_pulse = 1'b1;
        @(posedge clk);
        #1;
        ovf_pulse = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        trg_pin = 1'b1;
    endtask : fall_trg
    task automatic cnt_pulses(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
            cnt_pin = 1'b0;
            repeat (3) @(posedge clk);
            #1;
            cnt_pin = 1'b1;
            repeat (3) @(posedge clk);
        end
    endtask : cnt_pulses
endmodule : crt_pins

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic       clk, sys_rst, ce, sfr_wr, sfr_rd, cnt, trg, oto;
    logic       irq, ovp, rxc, txc, rx_seen, tx_seen;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rv, md, h;
    logic [7:0] m [256];
    logic [7:0] tmd [3] = '{8'h01, 8'h09, 8'h38};
    logic [7:0] omd [4] = '{8'h04, 8'h05, 8'h24, 8'h15};
    int         n_errors;
    int         checks;
    crt_timer u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .external_count_pin(cnt), .trigger_pin(trg),
        .other_timer_ovf(oto), .irq(irq), .overflow_pulse(ovp),
        .uart_rx_clk(rxc), .uart_tx_clk(txc));
    crt_pins u_pins (.clk(clk), .trg_pin(trg), .cnt_pin(cnt),
        .ovf_pulse(oto));
    // ----------------------------------------------------------------
    // bus tasks and register model
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        #1;
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = w;
        sfr_rd    = !w;
        @(posedge clk);
        #1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        rv     = sfr_rdata;
        if (w && a inside {[8'hC8:8'hCC]})
            m[a] = d;
    endtask : bus
    task automatic rd8(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), rv, m[a]);
    endtask : rd8
    task automatic close_out();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        #200us;
        n_errors++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'hC5CD3DA4));
        {sys_rst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 19'h40000;
        ce = 1'b1;
        foreach (m[i]) m[i] = 8'h00;
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        bus(1'b1, 8'hC7, 8'h5A);
        for (int a = 8'hC6; a <= 8'hCE; a++)
            rd8(8'(a));
        repeat (4)
        begin
            md = 8'($urandom) & 8'hFB;
            bus(1'b1, 8'hC8, md);
            rd8(8'hC8);
            chk("irq", irq, {7'h0, |md[7:6]});
        end
        for (int i = 0; i < 3; i++)
        begin
            md = tmd[i];
            bus(1'b1, 8'hC8, md);
            bus(1'b1, 8'hC9, 8'($urandom));
            bus(1'b1, 8'hCA, 8'($urandom));
            u_pins.fall_trg();
            repeat (6) @(posedge clk);
            if (md[3])
                m[8'hC8] = md | 8'h40;
            if (md == 8'h09)
                {m[8'hCC], m[8'hCB]} = {m[8'hCA], m[8'hC9]};
            for (int a = 8'hC8; a <= 8'hCC; a++)
                rd8(8'(a));
            chk("irq", irq, {7'h0, md[3]});
            bus(1'b1, 8'hC8, 8'h00);
        end
        for (int i = 0; i < 2; i++)
        begin
            md = i ? 8'h3C : 8'h0C;
            h = 8'($urandom);
            bus(1'b1, 8'hCB, 8'h00);
            bus(1'b1, 8'hCC, h);
            bus(1'b1, 8'hC9, 8'h00);
            bus(1'b1, 8'hCA, 8'h10);
            bus(1'b1, 8'hC8, md);
            u_pins.fall_trg();
            repeat (6) @(posedge clk);
            m[8'hC8] = md | 8'h40;
            rd8(8'hC8);
            bus(1'b1, 8'hC8, 8'h00);
            m[8'hCA] = md[5] ? 8'h10 : h;
            rd8(8'hCA);
        end
        for (int i = 0; i < 4; i++)
        begin
            md = omd[i];
            h = 8'($urandom);
            bus(1'b1, 8'hCB, 8'h00);
            bus(1'b1, 8'hCC, h);
            bus(1'b1, 8'hC9, 8'hF0);
            bus(1'b1, 8'hCA, 8'hFF);
            {rx_seen, tx_seen} = 2'b00;
            bus(1'b1, 8'hC8, md);
            repeat (800)
            begin
                @(posedge clk);
                #1;
                rx_seen = rx_seen | rxc;
                tx_seen = tx_seen | txc;
                if (ovp)
                    break;
            end
            chk("ovf", ovp, 8'h01);
            m[8'hC8] = md | (md[5:4] == 2'b00 ? 8'h80 : 8'h00);
            rd8(8'hC8);
            chk("irq", irq, m[8'hC8][7]);
            chk("rxclk", rx_seen, md[5]);
            chk("txclk", tx_seen, md[4]);
            bus(1'b1, 8'hC8, 8'h00);
            m[8'hCA] = md == 8'h05 ? 8'h00 : h;
            rd8(8'hCA);
        end
        bus(1'b1, 8'hC9, 8'h00);
        bus(1'b1, 8'hC8, 8'h06);
        u_pins.cnt_pulses(5);
        repeat (6) @(posedge clk);
        bus(1'b1, 8'hC8, 8'h02);
        m[8'hC9] = 8'h05;
        rd8(8'hC9);
        u_pins.cnt_pulses(3);
        rd8(8'hC9);
        bus(1'b1, 8'hC9, 8'h00);
        bus(1'b1, 8'hC8, 8'h04);
        repeat (120) @(posedge clk);
        bus(1'b1, 8'hC8, 8'h00);
        bus(1'b0, 8'hC9, 8'h00);
        chk("rate", {7'h0, rv >= 8'h09 && rv <= 8'h0B}, 8'h01);
        // running timer with enable low must not advance at all
        bus(1'b1, 8'hC9, 8'h00);
        bus(1'b1, 8'hC8, 8'h04);
        ce = 1'b0;
        repeat (60) @(posedge clk);
        #1;
        ce = 1'b1;
        bus(1'b1, 8'hC8, 8'h00);
        rd8(8'hC9);
        close_out();
    end
endmodule : tb
